// ==== hw/jbsp_top.sv ====
// Purpose: boundary-scan test access port with pin control and a configuration path
// Assumes: tck is the link clock, clock is the core clock at 200 MHz
// Notes:   pins are muxed in the core domain; test values cross by toggle
//
// Overview of operation
// [RULE_01] The tap state machine and instructions follow the 1990 boundary-scan standard.
// [RULE_02] Boundary tests act only while unconfigured or configured, never mid-configuration.
// [RULE_03] The scan chain may rewrite each pin's I/O standard at any time.
// [RULE_04] Sample/preload snapshots the pins without disturbing them and preloads a pattern.
// [RULE_05] Extest drives the boundary pattern onto pins and captures input levels.
// [RULE_06] Bypass puts one flip-flop between tdi and tdo.
// [RULE_07] Configuration data may be loaded through the test port.
// [RULE_08] User outputs stay undriven until configuration is complete.
// [RULE_09] The instruction register is 10 bits, shifted in lsb first.
// [RULE_10] A new instruction takes effect at update-ir; test-logic reset selects bypass.
// [RULE_11] Tdo changes on the falling tck edge and is driven only in the shift states.
`default_nettype none

module jbsp_top #(
   parameter int unsigned N_IO  = 8,
   parameter int unsigned STD_W = 3
) (
   input  wire logic                        clock,
   input  wire logic                        rst_n,
   input  wire logic                        tck,
   input  wire logic                        trst_n,
   input  wire logic                        tms,
   input  wire logic                        tdi,
   output logic                             tdo,
   output logic                             tdo_oe,
   input  wire logic [N_IO-1:0]             pin_in,
   output logic      [N_IO-1:0]             pin_out,
   output logic      [N_IO-1:0]             pin_oe,
   output logic      [N_IO*STD_W-1:0]       io_std,
   input  wire logic [N_IO-1:0]             user_out,
   input  wire logic [N_IO-1:0]             user_oe,
   input  wire logic                        config_busy,
   input  wire logic                        config_done,
   output logic      [jbsp_pkg::CFG_W-1:0]  cfg_data,
   output logic                             cfg_valid
);
   import jbsp_pkg::*;

   localparam int unsigned BSR_LEN = N_IO * CELL_BITS;
   localparam int unsigned STD_LEN = N_IO * STD_W;

   if (N_IO < 1 || STD_W < 1) begin : g_bad_params
      $error("jbsp_top: N_IO and STD_W must be at least 1");
   end

   // ---------------- link (tck) domain ----------------
   jbsp_tap_t            tap, next_tap;
   logic [IR_LEN-1:0]    ir_sh, next_ir_sh, ir, next_ir;
   logic                 byp, next_byp;
   logic [BSR_LEN-1:0]   bsr_sh, next_bsr_sh, bsr_upd, next_bsr_upd;
   logic [STD_LEN-1:0]   std_sh, next_std_sh, std_upd, next_std_upd;
   logic [CFG_W-1:0]     cfg_sh, next_cfg_sh, cfg_upd, next_cfg_upd;
   logic                 upd_tgl, next_upd_tgl, cfg_tgl, next_cfg_tgl;
   logic                 ext_mode, next_ext_mode;
   logic [N_IO+1:0]      tck_sync;
   logic [N_IO-1:0]      pins_s;
   logic                 busy_s, done_s;
   logic                 tdo_bit, next_tdo_bit, next_tdo_oe;

   assign pins_s = tck_sync[N_IO-1:0];
   assign busy_s = tck_sync[N_IO];
   assign done_s = tck_sync[N_IO+1];

   jbsp_sync #(.W(N_IO + 2)) u_tck_sync (
      .clock (tck),
      .rst_n (trst_n),
      .d     ({config_done, config_busy, pin_in}),
      .q     (tck_sync)
   );

   function automatic jbsp_tap_t tap_step(input jbsp_tap_t s, input logic m);
      case (s)
         TLR:     tap_step = m ? TLR    : RTI;
         RTI:     tap_step = m ? SEL_DR : RTI;
         SEL_DR:  tap_step = m ? SEL_IR : CAP_DR;
         CAP_DR:  tap_step = m ? EX1_DR : SH_DR;
         SH_DR:   tap_step = m ? EX1_DR : SH_DR;
         EX1_DR:  tap_step = m ? UPD_DR : PA_DR;
         PA_DR:   tap_step = m ? EX2_DR : PA_DR;
         EX2_DR:  tap_step = m ? UPD_DR : SH_DR;
         UPD_DR:  tap_step = m ? SEL_DR : RTI;
         SEL_IR:  tap_step = m ? TLR    : CAP_IR;
         CAP_IR:  tap_step = m ? EX1_IR : SH_IR;
         SH_IR:   tap_step = m ? EX1_IR : SH_IR;
         EX1_IR:  tap_step = m ? UPD_IR : PA_IR;
         PA_IR:   tap_step = m ? EX2_IR : PA_IR;
         EX2_IR:  tap_step = m ? UPD_IR : SH_IR;
         UPD_IR:  tap_step = m ? SEL_DR : RTI;
         default: tap_step = TLR;
      endcase
   endfunction

   always_comb begin
      next_tap      = tap_step(tap, tms); // [RULE_01]
      next_ir_sh    = ir_sh;
      next_ir       = ir;
      next_byp      = byp;
      next_bsr_sh   = bsr_sh;
      next_bsr_upd  = bsr_upd;
      next_std_sh   = std_sh;
      next_std_upd  = std_upd;
      next_cfg_sh   = cfg_sh;
      next_cfg_upd  = cfg_upd;
      next_upd_tgl  = upd_tgl;
      next_cfg_tgl  = cfg_tgl;
      // pins are only handed to the chain outside configuration
      next_ext_mode = (ir == IR_EXTEST) && !(busy_s && !done_s); // [RULE_02] [RULE_05]
      case (tap)
         TLR: begin
            next_ir = IR_BYPASS; // [RULE_10]
         end
         CAP_IR: begin
            next_ir_sh = IR_CAPTURE;
         end
         SH_IR: begin
            next_ir_sh = {tdi, ir_sh[IR_LEN-1:1]}; // [RULE_09]
         end
         UPD_IR: begin
            next_ir = ir_sh; // [RULE_10]
         end
         CAP_DR: begin
            next_byp = 1'b0;
            if (ir == IR_SAMPLE || ir == IR_EXTEST) begin
               // snapshot only; pins keep their current drivers
               for (int i = 0; i < N_IO; i++) begin
                  next_bsr_sh[i*CELL_BITS+CELL_IN]  = pins_s[i]; // [RULE_04] [RULE_05]
                  next_bsr_sh[i*CELL_BITS+CELL_OUT] = bsr_upd[i*CELL_BITS+CELL_OUT];
                  next_bsr_sh[i*CELL_BITS+CELL_OE]  = bsr_upd[i*CELL_BITS+CELL_OE];
               end
            end else if (ir == IR_IO_STD) begin
               next_std_sh = std_upd;
            end
         end
         SH_DR: begin
            case (ir)
               IR_SAMPLE, IR_EXTEST: next_bsr_sh = {tdi, bsr_sh[BSR_LEN-1:1]};
               IR_IO_STD:            next_std_sh = {tdi, std_sh[STD_LEN-1:1]};
               IR_CFG_LOAD:          next_cfg_sh = {tdi, cfg_sh[CFG_W-1:1]};
               default:              next_byp    = tdi; // [RULE_06]
            endcase
         end
         UPD_DR: begin
            case (ir)
               IR_SAMPLE, IR_EXTEST: begin
                  next_bsr_upd = bsr_sh; // [RULE_04]
                  next_upd_tgl = !upd_tgl;
               end
               IR_IO_STD: begin
                  // allowed in any configuration phase
                  next_std_upd = std_sh; // [RULE_03]
                  next_upd_tgl = !upd_tgl;
               end
               IR_CFG_LOAD: begin
                  next_cfg_upd = cfg_sh; // [RULE_07]
                  next_cfg_tgl = !cfg_tgl;
               end
               default: begin
               end
            endcase
         end
         default: begin
         end
      endcase
   end

   always_ff @(posedge tck) begin
      if (!trst_n) begin
         tap      <= TLR;
         ir_sh    <= '0;
         ir       <= IR_BYPASS;
         byp      <= 1'b0;
         bsr_sh   <= '0;
         bsr_upd  <= '0;
         std_sh   <= '0;
         std_upd  <= '0;
         cfg_sh   <= '0;
         cfg_upd  <= '0;
         upd_tgl  <= 1'b0;
         cfg_tgl  <= 1'b0;
         ext_mode <= 1'b0;
      end else begin
         tap      <= next_tap;
         ir_sh    <= next_ir_sh;
         ir       <= next_ir;
         byp      <= next_byp;
         bsr_sh   <= next_bsr_sh;
         bsr_upd  <= next_bsr_upd;
         std_sh   <= next_std_sh;
         std_upd  <= next_std_upd;
         cfg_sh   <= next_cfg_sh;
         cfg_upd  <= next_cfg_upd;
         upd_tgl  <= next_upd_tgl;
         cfg_tgl  <= next_cfg_tgl;
         ext_mode <= next_ext_mode;
      end
   end

   always_comb begin
      next_tdo_oe  = (tap == SH_DR) || (tap == SH_IR); // [RULE_11]
      next_tdo_bit = byp;
      if (tap == SH_IR) begin
         next_tdo_bit = ir_sh[0];
      end else begin
         case (ir)
            IR_SAMPLE, IR_EXTEST: next_tdo_bit = bsr_sh[0];
            IR_IO_STD:            next_tdo_bit = std_sh[0];
            IR_CFG_LOAD:          next_tdo_bit = cfg_sh[0];
            default:              next_tdo_bit = byp; // [RULE_06]
         endcase
      end
   end

   // falling edge gives the far end a half period of hold
   always_ff @(negedge tck) begin
      if (!trst_n) begin
         tdo_bit <= 1'b0;
         tdo_oe  <= 1'b0;
      end else begin
         tdo_bit <= next_tdo_bit; // [RULE_11]
         tdo_oe  <= next_tdo_oe;
      end
   end
   assign tdo = tdo_bit;

   // ---------------- core (clock) domain ----------------
   logic [2:0]           core_sync;
   logic                 upd_seen, next_upd_seen, cfg_seen, next_cfg_seen;
   logic [N_IO-1:0]      tst_out, next_tst_out, tst_oe, next_tst_oe;
   logic [N_IO-1:0]      next_pin_out, next_pin_oe;
   logic [STD_LEN-1:0]   next_io_std;
   logic [CFG_W-1:0]     next_cfg_data;
   logic                 next_cfg_valid;

   jbsp_sync #(.W(3)) u_core_sync (
      .clock (clock),
      .rst_n (rst_n),
      .d     ({ext_mode, cfg_tgl, upd_tgl}),
      .q     (core_sync)
   );

   always_comb begin
      next_upd_seen  = core_sync[0];
      next_cfg_seen  = core_sync[1];
      next_tst_out   = tst_out;
      next_tst_oe    = tst_oe;
      next_io_std    = io_std;
      next_cfg_data  = cfg_data;
      next_cfg_valid = 1'b0;
      // tck-side words hold still for many core clocks after a toggle
      if (core_sync[0] != upd_seen) begin
         for (int i = 0; i < N_IO; i++) begin
            next_tst_out[i] = bsr_upd[i*CELL_BITS+CELL_OUT];
            next_tst_oe[i]  = bsr_upd[i*CELL_BITS+CELL_OE];
         end
         next_io_std = std_upd; // [RULE_03]
      end
      if (core_sync[1] != cfg_seen) begin
         next_cfg_data  = cfg_upd; // [RULE_07]
         next_cfg_valid = 1'b1;
      end
      if (core_sync[2]) begin
         next_pin_out = tst_out; // [RULE_05]
         next_pin_oe  = tst_oe;
      end else begin
         next_pin_out = user_out;
         next_pin_oe  = config_done ? user_oe : '0; // [RULE_08]
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         upd_seen  <= 1'b0;
         cfg_seen  <= 1'b0;
         tst_out   <= '0;
         tst_oe    <= '0;
         io_std    <= '0;
         cfg_data  <= '0;
         cfg_valid <= 1'b0;
         pin_out   <= '0;
         pin_oe    <= '0; // [RULE_08]
      end else begin
         upd_seen  <= next_upd_seen;
         cfg_seen  <= next_cfg_seen;
         tst_out   <= next_tst_out;
         tst_oe    <= next_tst_oe;
         io_std    <= next_io_std;
         cfg_data  <= next_cfg_data;
         cfg_valid <= next_cfg_valid;
         pin_out   <= next_pin_out;
         pin_oe    <= next_pin_oe;
      end
   end
endmodule

`default_nettype wire

// ==== hw/jbsp_sync.sv ====
// Purpose: package of shared constants, and a three-stage level synchroniser
// Assumes: source signals are levels or toggles that hold for several destination clocks
// Notes:   output follows only once the second and third stages agree
`default_nettype none

package jbsp_pkg;
   localparam int unsigned IR_LEN      = 10;
   localparam logic [9:0]  IR_EXTEST   = 10'h000;
   localparam logic [9:0]  IR_SAMPLE   = 10'h005;
   localparam logic [9:0]  IR_BYPASS   = 10'h3FF;
   localparam logic [9:0]  IR_IO_STD   = 10'h00D;
   localparam logic [9:0]  IR_CFG_LOAD = 10'h002;
   localparam logic [9:0]  IR_CAPTURE  = 10'h001;
   localparam int unsigned CFG_W       = 8;
   localparam int unsigned CELL_BITS   = 3;
   localparam int unsigned CELL_IN     = 0;
   localparam int unsigned CELL_OUT    = 1;
   localparam int unsigned CELL_OE     = 2;
   localparam int unsigned SYNC_STAGES = 3;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
   } jbsp_tap_t;
endpackage

module jbsp_sync #(
   parameter int unsigned W = 1
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   import jbsp_pkg::*;
   logic [W-1:0] s1, s2, s3, next_q;

   if (W < 1) begin : g_bad_width
      $error("jbsp_sync: W must be at least 1");
   end

   always_comb begin
      next_q = q;
      // first stage is read only by the second
      for (int i = 0; i < W; i++) begin
         if (s2[i] == s3[i]) begin
            next_q[i] = s3[i];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         q  <= '0;
      end else begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q  <= next_q;
      end
   end
endmodule

`default_nettype wire

// ==== sim/jbsp_assertions.sv ====
// Purpose: port-level checks of the scan port
// Assumes: tck stands low between frames
// Notes:   tdo_oe is judged at the rise after the fall that moved it
`default_nettype none
module jbsp_assertions #(
   parameter int unsigned N_IO = 8
) (
   input wire logic                       clock,
   input wire logic                       rst_n,
   input wire logic                       tck,
   input wire logic                       trst_n,
   input wire logic                       tms,
   input wire logic                       tdo_oe,
   input wire logic [N_IO-1:0]            pin_out,
   input wire logic [N_IO-1:0]            pin_oe,
   input wire logic                       config_busy,
   input wire logic                       config_done,
   input wire logic [jbsp_pkg::CFG_W-1:0] cfg_data,
   input wire logic                       cfg_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   // no disable: the antecedent is the reset itself
   AST_RST_QUIET: assert property (@(posedge clock)
      !rst_n |=> pin_oe == '0 && pin_out == '0 && !cfg_valid)
      else $error("core outputs active after reset");
   AST_CFG_PULSE: assert property (@(posedge clock) disable iff (!rst_n) cfg_valid |=> !cfg_valid)
      else $error("cfg_valid longer than one clock");
   AST_CFG_HOLD: assert property (@(posedge clock) disable iff (!rst_n) !cfg_valid |-> $stable(cfg_data))
      else $error("cfg_data moved without cfg_valid");
   AST_OE_BUSY: assert property (@(posedge clock) disable iff (!rst_n)
      (config_busy && !config_done)[*8] ##1 (config_busy && !config_done)[*8]
      ##1 (config_busy && !config_done)[*8] |-> pin_oe == '0)
      else $error("pins driven while configuring");
   AST_TRST_IDLE: assert property (@(posedge tck) !trst_n |=> !tdo_oe)
      else $error("tdo driven after tap reset");
   AST_SHIFT_EXIT: assert property (@(posedge tck) disable iff (!trst_n) tdo_oe && tms |=> !tdo_oe)
      else $error("tdo still driven after leaving shift");
   AST_SHIFT_STAY: assert property (@(posedge tck) disable iff (!trst_n) tdo_oe && !tms |=> tdo_oe)
      else $error("tdo released while shifting");
   AST_OE_ENTRY: assert property (@(posedge tck) disable iff (!trst_n)
      $rose(tdo_oe) |-> !$past(tms))
      else $error("tdo driven without capture then shift");
endmodule
bind jbsp_top jbsp_assertions #(.N_IO(N_IO)) u_chk (.clock(clock), .rst_n(rst_n), .tck(tck),
   .trst_n(trst_n), .tms(tms), .tdo_oe(tdo_oe), .pin_out(pin_out), .pin_oe(pin_oe),
   .config_busy(config_busy), .config_done(config_done), .cfg_data(cfg_data),
   .cfg_valid(cfg_valid));
`default_nettype wire

// ==== sim/jbsp_jtag_ctrl.sv ====
// Purpose: model of the external test controller
// Assumes: 12 ns tck, low and still outside frames
// Notes:   an undriven tdo reads inverted, so a stray sample shows up
`default_nettype none
module jbsp_jtag_ctrl (
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   task automatic tick(input logic m, input logic d, output logic q);
      tms <= m;
      tdi <= d;
      #6 tck = 1'b1;
      q = tdo_oe ? tdo : ~tdo;
      #6 tck = 1'b0;
   endtask
   task automatic idle(input int n);
      logic q;
      repeat (n) tick(1'b0, 1'b0, q);
   endtask
   // from idle: select, capture, shift n bits lsb first, update, idle
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      tick(1'b1, 1'b0, q);
      if (ir) tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
      tick(1'b0, 1'b0, q);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tick(1'b1, 1'b0, q);
      tick(1'b0, 1'b0, q);
   endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: self-checking bench of the scan port
// Assumes: default sizes, eight pins of three-bit standards
// Notes:   core-side waits cover the toggle crossing
`default_nettype none
module tb_top;
   import jbsp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst_n, trst_n, tck, tms, tdi, tdo, tdo_oe, config_busy, config_done, cfg_valid;
   logic [7:0]  pin_in, pin_out, pin_oe, user_out, user_oe, cfg_data;
   logic [23:0] io_std;
   logic [7:0]  exp_q[$];
   int          errors, n_compared, cycles;
   int          seed = 32'h4c838beb;
   jbsp_top uut (.clock(clock), .rst_n(rst_n), .tck(tck), .trst_n(trst_n), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .io_std(io_std), .user_out(user_out), .user_oe(user_oe),
      .config_busy(config_busy), .config_done(config_done), .cfg_data(cfg_data),
      .cfg_valid(cfg_valid));
   jbsp_jtag_ctrl ctrl (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic summarize;
      if (errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic wait_core;
      // busy needs four tck rises to cross and one more to reach ext mode
      ctrl.idle(8);
      repeat (30) @(posedge clock);
   endtask
   task automatic load_ir(input logic [9:0] code);
      logic [31:0] q;
      ctrl.scan(1'b1, IR_LEN, {22'h0, code}, q);
      check("ir_capture", 32'h001, {22'h0, q[9:0]});
   endtask
   task automatic bypass_chk;
      logic [31:0] d, q;
      d = $random(seed);
      ctrl.scan(1'b0, 9, d, q);
      check("bypass", {23'h0, d[7:0], 1'b0}, {23'h0, q[8:0]});
   endtask
   // pattern: out values in [7:0], enables in [15:8]
   task automatic bsr_scan(input logic [15:0] pat);
      logic [31:0] d, q;
      d = '0;
      @(posedge clock) pin_in <= $random(seed);
      ctrl.idle(4);
      for (int i = 0; i < 8; i++) begin
         d[3*i+1] = pat[i];
         d[3*i+2] = pat[i+8];
      end
      ctrl.scan(1'b0, 24, d, q);
      for (int i = 0; i < 8; i++) check("pin_capture", pin_in[i], q[3*i]);
      wait_core();
   endtask
   always @(negedge clock) begin
      if (rst_n && cfg_valid === 1'b1) begin
         check("cfg_data", exp_q.size() > 0 ? exp_q.pop_front() : 'x, cfg_data);
      end
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      logic [31:0] d, q;
      logic        b;
      {rst_n, trst_n, config_busy, config_done, pin_in} = '0;
      {user_out, user_oe} = 16'hA5C3;
      {errors, n_compared, cycles} = '0;
      ctrl.idle(3);
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      trst_n <= 1'b1;
      ctrl.idle(1);
      check("pin_oe_reset", 0, pin_oe);
      check("io_std_reset", 0, io_std);
      bypass_chk();
      load_ir(10'h155);
      bypass_chk();
      load_ir(IR_SAMPLE);
      d = $random(seed);
      bsr_scan(d[15:0]);
      check("sample_oe", 0, pin_oe);
      load_ir(IR_EXTEST);
      wait_core();
      check("ext_out", d[7:0], pin_out);
      d = $random(seed);
      bsr_scan(d[15:0]);
      check("ext_oe", d[15:8], pin_oe);
      @(posedge clock) config_busy <= 1'b1;
      wait_core();
      check("busy_oe", 0, pin_oe);
      @(posedge clock) config_busy <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         @(posedge clock) config_done <= k[0];
         load_ir(IR_IO_STD);
         d = $random(seed);
         ctrl.scan(1'b0, 24, d, q);
         wait_core();
         check("io_std", {8'h0, d[23:0]}, {8'h0, io_std});
      end
      load_ir(IR_CFG_LOAD);
      repeat (2) begin
         d = $random(seed);
         exp_q.push_back(d[7:0]);
         ctrl.scan(1'b0, CFG_W, d, q);
      end
      repeat (5) ctrl.tick(1'b1, 1'b0, b);
      ctrl.idle(1);
      bypass_chk();
      @(posedge clock) {user_out, user_oe} <= $random(seed);
      wait_core();
      check("user_oe", user_oe, pin_oe);
      check("user_out", user_out, pin_out);
      check("cfg_left", 0, exp_q.size());
      summarize();
   end
endmodule
`default_nettype wire
